// file: rtl/ubvc_defines.svh
// Purpose: register offsets, field positions and reset values of the USB pull and boost control
// Assumes: 16-bit register port, word index addressing
// Notes: definitions only
`ifndef UBVC_DEFINES_SVH
`define UBVC_DEFINES_SVH

// ----------------------------------------------------------------
// register index on the plain port
// ----------------------------------------------------------------
`define UBVC_ADDR_W 3
`define UBVC_ADDR_OTGCON 3'h0
`define UBVC_ADDR_PWRC 3'h1
`define UBVC_ADDR_PWMRRS 3'h2
`define UBVC_ADDR_PWMCON 3'h3
`define UBVC_ADDR_STAT 3'h4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UBVC_OTG_PULLUP 7
`define UBVC_OTG_DP_PD 5
`define UBVC_OTG_DM_PD 4
`define UBVC_OTG_VGEN_EN 3
`define UBVC_OTG_VSEL 1
`define UBVC_OTG_DISCH 0
`define UBVC_PWR_ON 0
`define UBVC_RATE_PER_LSB 0
`define UBVC_RATE_DUTY_LSB 8
`define UBVC_PWMCON_MOD_EN 15
`define UBVC_PWMCON_POL 9
`define UBVC_PWMCON_CNT_EN 8
`define UBVC_STAT_VBUS_OK 0
`define UBVC_STAT_OC_SEEN 1
`define UBVC_STAT_STATE_LSB 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UBVC_RST_BIT 1'b0
`define UBVC_RST_RATE 16'h0000
`define UBVC_RST_WORD 16'h0000
`define UBVC_RST_CNT 8'h00

`endif

// file: rtl/ubvc_pkg.sv
// Purpose: shared types of the USB pull and boost control
// Assumes: nothing beyond the defines header
// Notes: constants live in ubvc_defines.svh
package ubvc_pkg;

	// ----------------------------------------------------------------
	// boost generation state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		UBVC_GEN_OFF = 2'b00,
		UBVC_GEN_RUN = 2'b01,
		UBVC_GEN_LIMIT = 2'b10
	} ubvc_gen_state_t;

endpackage : ubvc_pkg

// file: rtl/ubvc_boost_pwm.sv
// Purpose: boost assist pwm counter and registered output
// Assumes: period and duty held stable by software while running
// Notes: output sits at the polarity level whenever no pulse is allowed
`include "ubvc_defines.svh"

module ubvc_boost_pwm (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cnt_en,
	input wire logic pulse_allow,
	input wire logic polarity,
	input wire logic [7:0] period,
	input wire logic [7:0] duty,
	output logic period_start,
	output logic pwm_out_q
);

	logic [7:0] count_q;

	// ----------------------------------------------------------------
	// period counter
	// ----------------------------------------------------------------
	// counter held at zero while disabled, wraps after reaching the period
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= `UBVC_RST_CNT;
		end else if (!cnt_en) begin
			count_q <= `UBVC_RST_CNT;
		end else if (count_q >= period) begin
			count_q <= `UBVC_RST_CNT;
		end else begin
			count_q <= count_q + 8'h01;
		end
	end

	assign period_start = cnt_en && (count_q == 8'h00);

	// ----------------------------------------------------------------
	// output stage
	// ----------------------------------------------------------------
	// xor keeps the idle level equal to the polarity bit, so the switch stays off
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pwm_out_q <= `UBVC_RST_BIT;
		end else begin
			pwm_out_q <= polarity ^ (pulse_allow && cnt_en && (count_q < duty));
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_counter_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!cnt_en |=> count_q == 8'h00)
		else $error("pwm counter moved while disabled");

	a_counter_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cnt_en && (count_q >= period) |=> count_q == 8'h00)
		else $error("pwm counter failed to wrap at period");

	a_duty_shape: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pulse_allow && cnt_en && (count_q < duty) |=> pwm_out_q == !$past(polarity))
		else $error("pwm pulse missing or wrong sense");

endmodule : ubvc_boost_pwm

// file: rtl/ubvc_ctrl.sv
// Purpose: USB OTG pull resistor switching and VBUS boost assist control
// Assumes: register port and comparator inputs synchronous to clk_sys
// Notes: software sequences the enables; the block only gates on them
//
// What this block does
// - pull-up bit connects D+ 1.5k pull-up
// - two pull-down bits connect 15k pull-downs
// - polarity bit sets pwm output sense
// - target select picks regulated VBUS level
// - counter runs only when counter enabled
// - pwm active only when module enabled
// - generation starts only with enable bit
// - pwm drives supply, comparators limit
// - suspend never releases enabled pull-up
`include "ubvc_defines.svh"

module ubvc_ctrl (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [`UBVC_ADDR_W-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata_q,
	input wire logic usb_suspend,
	input wire logic vbus_above_target,
	input wire logic vbus_overcurrent,
	output logic dplus_pullup_en,
	output logic dplus_pulldown_en,
	output logic dminus_pulldown_en,
	output logic vbus_target_select,
	output logic vbus_discharge_en,
	output logic usb_power_en,
	output logic boost_pwm_out
);

	logic wr_otg;
	logic wr_pwr;
	logic wr_rate;
	logic wr_pwmcon;
	logic wr_stat;
	logic vgen_en_q;
	logic [15:0] rate_q;
	logic boost_pwm_module_en_q;
	logic boost_pwm_polarity_q;
	logic boost_counter_en_q;
	logic oc_seen_q;
	logic gen_active;
	logic pulse_allow;
	logic period_start;
	logic [15:0] rd_mux;
	ubvc_pkg::ubvc_gen_state_t gen_state_q;
	ubvc_pkg::ubvc_gen_state_t gen_state_d;

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	assign wr_otg = reg_wr && (reg_addr == `UBVC_ADDR_OTGCON);
	assign wr_pwr = reg_wr && (reg_addr == `UBVC_ADDR_PWRC);
	assign wr_rate = reg_wr && (reg_addr == `UBVC_ADDR_PWMRRS);
	assign wr_pwmcon = reg_wr && (reg_addr == `UBVC_ADDR_PWMCON);
	assign wr_stat = reg_wr && (reg_addr == `UBVC_ADDR_STAT);

	// ----------------------------------------------------------------
	// otg control register: pulls, target level, generation enable
	// ----------------------------------------------------------------
	// suspend is deliberately not an input here, so it cannot drop the pull-up
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dplus_pullup_en <= `UBVC_RST_BIT;
			dplus_pulldown_en <= `UBVC_RST_BIT;
			dminus_pulldown_en <= `UBVC_RST_BIT;
			vgen_en_q <= `UBVC_RST_BIT;
			vbus_target_select <= `UBVC_RST_BIT;
			vbus_discharge_en <= `UBVC_RST_BIT;
		end else if (wr_otg) begin
			dplus_pullup_en <= reg_wdata[`UBVC_OTG_PULLUP];
			dplus_pulldown_en <= reg_wdata[`UBVC_OTG_DP_PD];
			dminus_pulldown_en <= reg_wdata[`UBVC_OTG_DM_PD];
			vgen_en_q <= reg_wdata[`UBVC_OTG_VGEN_EN];
			vbus_target_select <= reg_wdata[`UBVC_OTG_VSEL];
			vbus_discharge_en <= reg_wdata[`UBVC_OTG_DISCH];
		end
	end

	// ----------------------------------------------------------------
	// power control register
	// ----------------------------------------------------------------
	// readable so software can confirm power before starting generation
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			usb_power_en <= `UBVC_RST_BIT;
		end else if (wr_pwr) begin
			usb_power_en <= reg_wdata[`UBVC_PWR_ON];
		end
	end

	// ----------------------------------------------------------------
	// pwm rate and control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rate_q <= `UBVC_RST_RATE;
		end else if (wr_rate) begin
			rate_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			boost_pwm_module_en_q <= `UBVC_RST_BIT;
			boost_pwm_polarity_q <= `UBVC_RST_BIT;
			boost_counter_en_q <= `UBVC_RST_BIT;
		end else if (wr_pwmcon) begin
			boost_pwm_module_en_q <= reg_wdata[`UBVC_PWMCON_MOD_EN];
			boost_pwm_polarity_q <= reg_wdata[`UBVC_PWMCON_POL];
			boost_counter_en_q <= reg_wdata[`UBVC_PWMCON_CNT_EN];
		end
	end

	// ----------------------------------------------------------------
	// overcurrent sticky flag, write one to clear
	// ----------------------------------------------------------------
	// a new trip in the clearing cycle wins so no event is lost
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			oc_seen_q <= `UBVC_RST_BIT;
		end else if (vbus_overcurrent) begin
			oc_seen_q <= 1'b1;
		end else if (wr_stat && reg_wdata[`UBVC_STAT_OC_SEEN]) begin
			oc_seen_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// generation state machine
	// ----------------------------------------------------------------
	// limit holds pulses off until a fresh period with current back in range
	assign gen_active = vgen_en_q && boost_pwm_module_en_q;

	always_comb begin
		gen_state_d = gen_state_q;
		case (gen_state_q)
			ubvc_pkg::UBVC_GEN_OFF: begin
				if (gen_active) begin
					gen_state_d = ubvc_pkg::UBVC_GEN_RUN;
				end
			end
			ubvc_pkg::UBVC_GEN_RUN: begin
				if (!gen_active) begin
					gen_state_d = ubvc_pkg::UBVC_GEN_OFF;
				end else if (vbus_overcurrent) begin
					gen_state_d = ubvc_pkg::UBVC_GEN_LIMIT;
				end
			end
			ubvc_pkg::UBVC_GEN_LIMIT: begin
				if (!gen_active) begin
					gen_state_d = ubvc_pkg::UBVC_GEN_OFF;
				end else if (period_start && !vbus_overcurrent) begin
					gen_state_d = ubvc_pkg::UBVC_GEN_RUN;
				end
			end
			default: begin
				gen_state_d = ubvc_pkg::UBVC_GEN_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gen_state_q <= ubvc_pkg::UBVC_GEN_OFF;
		end else begin
			gen_state_q <= gen_state_d;
		end
	end

	// pulses skipped while the voltage comparator says the target is reached
	assign pulse_allow = (gen_state_q == ubvc_pkg::UBVC_GEN_RUN) && !vbus_above_target;

	// ----------------------------------------------------------------
	// pwm engine
	// ----------------------------------------------------------------
	ubvc_boost_pwm u_pwm (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cnt_en(boost_counter_en_q),
		.pulse_allow(pulse_allow),
		.polarity(boost_pwm_polarity_q),
		.period(rate_q[`UBVC_RATE_PER_LSB +: 8]),
		.duty(rate_q[`UBVC_RATE_DUTY_LSB +: 8]),
		.period_start(period_start),
		.pwm_out_q(boost_pwm_out)
	);

	// ----------------------------------------------------------------
	// read path, data one cycle after the strobe
	// ----------------------------------------------------------------
	always_comb begin
		rd_mux = `UBVC_RST_WORD;
		case (reg_addr)
			`UBVC_ADDR_OTGCON: begin
				rd_mux[`UBVC_OTG_PULLUP] = dplus_pullup_en;
				rd_mux[`UBVC_OTG_DP_PD] = dplus_pulldown_en;
				rd_mux[`UBVC_OTG_DM_PD] = dminus_pulldown_en;
				rd_mux[`UBVC_OTG_VGEN_EN] = vgen_en_q;
				rd_mux[`UBVC_OTG_VSEL] = vbus_target_select;
				rd_mux[`UBVC_OTG_DISCH] = vbus_discharge_en;
			end
			`UBVC_ADDR_PWRC: begin
				rd_mux[`UBVC_PWR_ON] = usb_power_en;
			end
			`UBVC_ADDR_PWMRRS: begin
				rd_mux = rate_q;
			end
			`UBVC_ADDR_PWMCON: begin
				rd_mux[`UBVC_PWMCON_MOD_EN] = boost_pwm_module_en_q;
				rd_mux[`UBVC_PWMCON_POL] = boost_pwm_polarity_q;
				rd_mux[`UBVC_PWMCON_CNT_EN] = boost_counter_en_q;
			end
			`UBVC_ADDR_STAT: begin
				rd_mux[`UBVC_STAT_VBUS_OK] = vbus_above_target;
				rd_mux[`UBVC_STAT_OC_SEEN] = oc_seen_q;
				rd_mux[`UBVC_STAT_STATE_LSB +: 2] = gen_state_q;
			end
			default: begin
				rd_mux = `UBVC_RST_WORD;
			end
		endcase
	end

	// unmapped reads return zero; data held only for the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_q <= `UBVC_RST_WORD;
		end else if (reg_rd) begin
			reg_rdata_q <= rd_mux;
		end else begin
			reg_rdata_q <= `UBVC_RST_WORD;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_pullup_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_otg |=> dplus_pullup_en == $past(reg_wdata[`UBVC_OTG_PULLUP]))
		else $error("pull-up did not follow its control bit");

	a_pulldown_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_otg && reg_wdata[`UBVC_OTG_DP_PD] && reg_wdata[`UBVC_OTG_DM_PD]
		|=> dplus_pulldown_en && dminus_pulldown_en)
		else $error("pull-downs not both connected");

	a_suspend_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
		dplus_pullup_en && usb_suspend && !wr_otg |=> dplus_pullup_en)
		else $error("pull-up dropped during suspend");

	a_target_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_otg |=> vbus_target_select == $past(reg_wdata[`UBVC_OTG_VSEL]))
		else $error("target select did not follow write");

	a_gen_needs_en: assert property (@(posedge clk_sys) disable iff (!rst_n)
		gen_state_q != ubvc_pkg::UBVC_GEN_OFF |-> $past(gen_active))
		else $error("generation running without both enables");

	a_idle_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		gen_state_q == ubvc_pkg::UBVC_GEN_OFF |=> boost_pwm_out == $past(boost_pwm_polarity_q))
		else $error("pwm output left idle level while generation off");

	a_oc_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		gen_state_q == ubvc_pkg::UBVC_GEN_RUN && gen_active && vbus_overcurrent
		|=> gen_state_q == ubvc_pkg::UBVC_GEN_LIMIT ##1 boost_pwm_out == $past(boost_pwm_polarity_q))
		else $error("overcurrent did not stop pulses");

	a_oc_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
		vbus_overcurrent |=> oc_seen_q)
		else $error("overcurrent trip lost");

	a_read_power: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && reg_addr == `UBVC_ADDR_PWRC |=> reg_rdata_q[`UBVC_PWR_ON] == $past(usb_power_en))
		else $error("power bit read back wrong");

	c_gen_run: cover property (@(posedge clk_sys) disable iff (!rst_n)
		gen_state_q == ubvc_pkg::UBVC_GEN_OFF ##1 gen_state_q == ubvc_pkg::UBVC_GEN_RUN);

	c_limit_recover: cover property (@(posedge clk_sys) disable iff (!rst_n)
		gen_state_q == ubvc_pkg::UBVC_GEN_LIMIT ##1 gen_state_q == ubvc_pkg::UBVC_GEN_RUN);

	c_suspend_pullup: cover property (@(posedge clk_sys) disable iff (!rst_n)
		dplus_pullup_en && usb_suspend);

	c_pwm_toggle: cover property (@(posedge clk_sys) disable iff (!rst_n)
		$changed(boost_pwm_out) && gen_state_q == ubvc_pkg::UBVC_GEN_RUN);

endmodule : ubvc_ctrl

// file: dv/ubvc_far_model.sv
// Purpose: far side of the boost assist, external supply and its comparators
// Assumes: supply charges one step on each active pwm cycle, never leaks
// Notes: hold_low and trip are commanded by the bench only
module ubvc_far_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic boost_pwm_out,
	input wire logic polarity,
	input wire logic hold_low,
	input wire logic trip,
	output logic vbus_above_target,
	output logic vbus_overcurrent
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] level_q;

	// ----------------------------------------------------------------
	// supply charge
	// ----------------------------------------------------------------
	// active sense depends on the external switch, hence the xor
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= 5'h00;
		end else if ((boost_pwm_out ^ polarity) && level_q != 5'h1F) begin
			level_q <= level_q + 5'h01;
		end
	end

	// comparators; hold_low pins the voltage reading below target
	assign vbus_above_target = !hold_low && level_q[4];
	assign vbus_overcurrent = trip;
endmodule : ubvc_far_model

// file: dv/usb_pullres_vbus_boost_ctrl_tb.sv
// Purpose: self-checking bench of the pull resistor and boost control
// Assumes: register port with read data one cycle after the strobe
// Notes: pwm counts use 8-cycle windows, a multiple of period+1
`include "ubvc_defines.svh"
module usb_pullres_vbus_boost_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic usb_suspend = 1'b0;
	logic hold_low = 1'b1;
	logic trip = 1'b0;
	logic reg_pol = 1'b0;
	logic [15:0] reg_rdata_q;
	logic vbus_above_target, vbus_overcurrent, boost_pwm_out, vbus_target_select;
	logic dplus_pullup_en, dplus_pulldown_en, dminus_pulldown_en, vbus_discharge_en;
	logic usb_power_en;
	logic [15:0] outs;
	logic [15:0] rd_q;
	int error_cnt = 0;
	int num_checks = 0;
	logic [15:0] hi_cnt;

	always #12.5 clk_sys = ~clk_sys;

	assign outs = {9'h000, dplus_pullup_en, dplus_pulldown_en, dminus_pulldown_en,
		vbus_target_select, vbus_discharge_en, usb_power_en, boost_pwm_out};

	ubvc_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.usb_suspend(usb_suspend), .vbus_above_target(vbus_above_target),
		.vbus_overcurrent(vbus_overcurrent), .dplus_pullup_en(dplus_pullup_en),
		.dplus_pulldown_en(dplus_pulldown_en), .dminus_pulldown_en(dminus_pulldown_en),
		.vbus_target_select(vbus_target_select), .vbus_discharge_en(vbus_discharge_en),
		.usb_power_en(usb_power_en), .boost_pwm_out(boost_pwm_out));

	ubvc_far_model u_far (.clk_sys(clk_sys), .rst_n(rst_n), .boost_pwm_out(boost_pwm_out),
		.polarity(reg_pol), .hold_low(hold_low), .trip(trip),
		.vbus_above_target(vbus_above_target), .vbus_overcurrent(vbus_overcurrent));

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// returns one edge after the strobe, so the write's effect is sampled settled
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr

	// data launched at the strobe's sampling edge is taken at the following edge
	task automatic rd(input logic [2:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		chk(reg_rdata_q, exp);
	endtask : rd

	// high cycles of the pwm pin over eight cycles; an unknown level poisons the sum
	task automatic pwm_hi(input logic [15:0] exp);
		repeat (4) @(posedge clk_sys);
		hi_cnt = 16'h0000;
		repeat (8) begin
			@(posedge clk_sys);
			hi_cnt = hi_cnt + {15'h0000, boost_pwm_out};
		end
		chk(hi_cnt, exp);
	endtask : pwm_hi

	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		chk(outs, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			rd(3'(i), 16'h0000);
		end
		// pull-up alone, then kept through suspend
		wr(`UBVC_ADDR_OTGCON, 16'h0080);
		chk(outs, 16'h0040);
		rd(`UBVC_ADDR_OTGCON, 16'h0080);
		usb_suspend <= 1'b1;
		pwm_hi(16'h0000);
		chk(outs, 16'h0040);
		usb_suspend <= 1'b0;
		// one pull-down alone tells the two bits apart, then the host pair
		wr(`UBVC_ADDR_OTGCON, 16'h0020);
		chk(outs, 16'h0020);
		wr(`UBVC_ADDR_OTGCON, 16'h0030);
		chk(outs, 16'h0030);
		// unmapped index takes nothing
		wr(3'h6, 16'hFFFF);
		rd(3'h6, 16'h0000);
		chk(outs, 16'h0030);
		// discharge and power are plain stored bits
		wr(`UBVC_ADDR_OTGCON, 16'h0031);
		chk(outs, 16'h0034);
		wr(`UBVC_ADDR_PWRC, 16'h0001);
		wr(`UBVC_ADDR_OTGCON, 16'h0030);
		rd(`UBVC_ADDR_PWRC, 16'h0001);
		rd(`UBVC_ADDR_OTGCON, 16'h0030);
		// enabling sequence: period 3 duty 1 gives 2 of 8 cycles
		wr(`UBVC_ADDR_PWMRRS, 16'h0103);
		rd(`UBVC_ADDR_PWMRRS, 16'h0103);
		wr(`UBVC_ADDR_OTGCON, 16'h0032);
		chk(outs, 16'h003A);
		wr(`UBVC_ADDR_PWMCON, 16'h0100);
		pwm_hi(16'h0000);
		wr(`UBVC_ADDR_PWMCON, 16'h8100);
		pwm_hi(16'h0000);
		wr(`UBVC_ADDR_OTGCON, 16'h003A);
		pwm_hi(16'h0002);
		wr(`UBVC_ADDR_PWMCON, 16'h8000);
		pwm_hi(16'h0000);
		wr(`UBVC_ADDR_PWMCON, 16'h0300);
		reg_pol <= 1'b1;
		pwm_hi(16'h0008);
		wr(`UBVC_ADDR_PWMCON, 16'h8300);
		pwm_hi(16'h0006);
		wr(`UBVC_ADDR_PWMCON, 16'h8100);
		reg_pol <= 1'b0;
		// overcurrent: limit state, sticky flag, write one to clear
		trip <= 1'b1;
		pwm_hi(16'h0000);
		rd(`UBVC_ADDR_STAT, 16'h000A);
		trip <= 1'b0;
		wr(`UBVC_ADDR_STAT, 16'h0002);
		pwm_hi(16'h0002);
		rd(`UBVC_ADDR_STAT, 16'h0004);
		// let the supply reach target: pulses cease; a miss still runs on to the report
		hold_low <= 1'b0;
		for (int i = 0; i < 200 && vbus_above_target !== 1'b1; i++) begin
			@(posedge clk_sys);
		end
		if (vbus_above_target !== 1'b1) begin
			error_cnt++;
			$display("Error %0t: supply never reached target", $time);
		end
		pwm_hi(16'h0000);
		rd(`UBVC_ADDR_STAT, 16'h0005);
		// orderly shutdown, power bit stays
		wr(`UBVC_ADDR_OTGCON, 16'h0000);
		chk(outs, 16'h0002);
		// second reset in mid-run, asserted and released on clock edges
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(outs, 16'h0000);
		rst_n <= 1'b1;
		rd(`UBVC_ADDR_PWMCON, 16'h0000);
		rd(`UBVC_ADDR_OTGCON, 16'h0000);
		wrap_up();
	end
endmodule : usb_pullres_vbus_boost_ctrl_tb
